// >>> rtl/pcs_codec_pkg.sv
package pcs_codec_pkg;

	// Code groups on the line
	localparam logic [4:0] SYM_IDLE = 5'h1f;
	localparam logic [4:0] SYM_J = 5'h18;
	localparam logic [4:0] SYM_K = 5'h11;
	localparam logic [4:0] SYM_T = 5'h0d;
	localparam logic [4:0] SYM_R = 5'h07;
	localparam logic [4:0] SYM_H = 5'h04;

	// Receive nibbles
	localparam logic [3:0] NIB_PREAMBLE = 4'h5;
	localparam logic [3:0] NIB_ZERO = 4'h0;
	localparam logic [3:0] ERR_UNLOCK = 4'h2;
	localparam logic [3:0] ERR_LINK = 4'h3;
	localparam logic [3:0] ERR_EARLY_END = 4'h6;
	localparam logic [3:0] ERR_INVALID = 4'h7;
	localparam logic [3:0] ERR_TX = 4'h8;
	localparam logic [3:0] ERR_FALSE = 4'he;

	// Stream cipher and framing
	localparam logic [10:0] LFSR_SEED = 11'h7ff;
	localparam logic [5:0] LOCK_MATCH_BITS = 6'h3c;
	localparam logic [1:0] MIN_IDLES = 2'h2;
	localparam logic [2:0] BITS_PER_SYM = 3'h5;
	localparam logic [2:0] AFTER_FIRST_ZERO = 3'h3;

	// Idle watch window
	localparam int CORE_CLK_MHZ = 100;
	localparam int IDLE_WINDOW_US = 724;
	localparam int IDLE_WINDOW_CYCLES = IDLE_WINDOW_US * CORE_CLK_MHZ;

	typedef enum logic [4:0] {
		RX_IDLE = 5'h01,
		RX_SSD = 5'h02,
		RX_DATA = 5'h04,
		RX_END = 5'h08,
		RX_FALSE = 5'h10
	} rx_state_e;

	typedef enum logic [3:0] {
		TX_IDLE = 4'h1,
		TX_SSD2 = 4'h2,
		TX_DATA = 4'h4,
		TX_ESD2 = 4'h8
	} tx_state_e;

	typedef struct packed {
		logic locked;
		logic [4:0] code;
	} rx_word_s;

	typedef struct packed {
		logic en;
		logic er;
		logic [3:0] d;
	} mii_tx_s;

	typedef struct packed {
		logic dv;
		logic er;
		logic [3:0] d;
		logic stb;
	} mii_rx_s;

	function automatic logic [4:0] enc_nibble(input logic [3:0] n);
		logic [4:0] t [16];
		t = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
			5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
		return t[n];
	endfunction

	// Returns {valid, nibble}; anything not a data code group is invalid
	function automatic logic [4:0] dec_symbol(input logic [4:0] c);
		logic [4:0] r;
		r = {1'b0, ERR_INVALID};
		for (int i = 0; i < 16; i++) begin
			if (enc_nibble(4'(i)) == c) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction

endpackage

// >>> rtl/fast_ethernet_pcs_codec.sv
module fast_ethernet_pcs_codec #(
	parameter int IDLE_WINDOW_CYCLES = pcs_codec_pkg::IDLE_WINDOW_CYCLES
) (
	// Clocks and reset
	input wire logic core_clk,
	input wire logic line_clk,
	input wire logic arst_n,
	// Mode and link monitor
	input wire logic speed_100,
	input wire logic full_duplex,
	input wire logic link_pass,
	// MII transmit
	input wire pcs_codec_pkg::mii_tx_s mii_tx,
	output logic tx_taken,
	// MII receive
	output pcs_codec_pkg::mii_rx_s mii_rx,
	output logic crs,
	output logic col,
	// Line bit stream
	input wire logic line_rx_bit,
	output logic line_tx_bit
);

	localparam int WIN_W = $clog2(IDLE_WINDOW_CYCLES + 1);

	if (IDLE_WINDOW_CYCLES < 2) begin : g_chk
		$error("IDLE_WINDOW_CYCLES must be at least 2");
	end

	typedef struct packed {
		logic link_m, link_s, speed_m, speed_s, full_m, full_s;
		logic act_m, act_s, act_arm;
		logic symt_m, symt_s, symt_d;
		logic reqt_m, reqt_s, reqt_d;
		pcs_codec_pkg::rx_state_e rxst;
		logic prev_idle;
		pcs_codec_pkg::mii_rx_s rx;
		logic crs, col;
		pcs_codec_pkg::tx_state_e txst;
		logic [4:0] tx_sym;
		logic tx_taken;
		logic [WIN_W-1:0] win_cnt;
		logic [1:0] idle_cnt;
		logic last_locked;
		logic unlock_tgl;
	} core_state_s;

	typedef struct packed {
		logic link_m, link_s, speed_m, speed_s;
		logic unl_m, unl_s, unl_d;
		logic [10:0] tx_lfsr;
		logic [2:0] tx_cnt;
		logic [4:0] tx_sh;
		logic tx_bit;
		logic req_tgl;
		logic [10:0] rx_lfsr;
		logic [5:0] good;
		logic locked, active, prev_idle;
		logic [2:0] rx_cnt;
		logic [4:0] rx_sh;
		pcs_codec_pkg::rx_word_s word;
		logic word_tgl;
	} line_state_s;

	localparam core_state_s CORE_RST = '{
		rxst: pcs_codec_pkg::RX_IDLE,
		txst: pcs_codec_pkg::TX_IDLE,
		tx_sym: pcs_codec_pkg::SYM_IDLE,
		default: '0
	};

	localparam line_state_s LINE_RST = '{
		tx_lfsr: pcs_codec_pkg::LFSR_SEED,
		tx_sh: pcs_codec_pkg::SYM_IDLE,
		word: '{1'b0, pcs_codec_pkg::SYM_IDLE},
		default: '0
	};

	core_state_s cq, cd;
	line_state_s lq, ld;

	logic sym_edge, req_edge, carrier, tx_busy;
	logic [4:0] dec;
	pcs_codec_pkg::rx_word_s w;
	logic key_t, key_r, force_unl, plain, enabled, idle_n;
	logic [2:0] cnt_n;
	logic [4:0] code_n;

	// Line side: serialiser, cipher, lock search and code group alignment
	always_comb begin
		ld = lq;
		ld.link_m = link_pass;
		ld.link_s = lq.link_m;
		ld.speed_m = speed_100;
		ld.speed_s = lq.speed_m;
		ld.unl_m = cq.unlock_tgl;
		ld.unl_s = lq.unl_m;
		ld.unl_d = lq.unl_s;

		key_t = lq.tx_lfsr[10] ^ lq.tx_lfsr[8];
		ld.tx_lfsr = {lq.tx_lfsr[9:0], key_t};
		ld.tx_bit = lq.tx_sh[4] ^ (lq.speed_s & key_t);
		if (lq.tx_cnt == pcs_codec_pkg::BITS_PER_SYM - 3'h1) begin
			// Word from the core is stable: it only changes after this toggle
			ld.tx_cnt = 3'h0;
			ld.tx_sh = cq.tx_sym;
			ld.req_tgl = ~lq.req_tgl;
		end else begin
			ld.tx_cnt = lq.tx_cnt + 3'h1;
			ld.tx_sh = {lq.tx_sh[3:0], 1'b0};
		end

		key_r = lq.rx_lfsr[10] ^ lq.rx_lfsr[8];
		force_unl = !lq.link_s || !lq.speed_s || (lq.unl_s ^ lq.unl_d);
		plain = line_rx_bit;
		if (force_unl) begin
			ld.locked = 1'b0;
			ld.good = 6'h0;
			ld.rx_lfsr = {lq.rx_lfsr[9:0], ~line_rx_bit};
		end else if (!lq.locked) begin
			// Idle is all ones, so the line bit is the inverted key
			ld.rx_lfsr = {lq.rx_lfsr[9:0], ~line_rx_bit};
			if (~line_rx_bit == key_r) begin
				if (lq.good == pcs_codec_pkg::LOCK_MATCH_BITS - 6'h1) begin
					ld.locked = 1'b1;
				end else begin
					ld.good = lq.good + 6'h1;
				end
			end else begin
				ld.good = 6'h0;
			end
		end else begin
			ld.rx_lfsr = {lq.rx_lfsr[9:0], key_r};
			plain = line_rx_bit ^ key_r;
		end

		enabled = !lq.speed_s || lq.locked;
		ld.rx_sh = {lq.rx_sh[3:0], plain};
		code_n = {lq.rx_sh[3:0], plain};
		idle_n = (code_n == pcs_codec_pkg::SYM_IDLE);
		cnt_n = lq.rx_cnt + 3'h1;
		if (!lq.active && enabled && !plain) begin
			// First zero after idle is the third bit of a group
			ld.active = 1'b1;
			ld.prev_idle = 1'b0;
			cnt_n = pcs_codec_pkg::AFTER_FIRST_ZERO;
		end
		if (cnt_n == pcs_codec_pkg::BITS_PER_SYM) begin
			ld.rx_cnt = 3'h0;
			ld.word = '{enabled, code_n};
			ld.word_tgl = ~lq.word_tgl;
			ld.prev_idle = idle_n;
			if (lq.active && ((idle_n && lq.prev_idle) || code_n == pcs_codec_pkg::SYM_R)) begin
				ld.active = 1'b0;
			end
		end else begin
			ld.rx_cnt = cnt_n;
		end
		if (!enabled) begin
			ld.active = 1'b0;
		end
	end

	always_ff @(posedge line_clk or negedge arst_n) begin
		if (!arst_n) begin
			lq <= LINE_RST;
		end else begin
			lq <= ld;
		end
	end

	// Core side: MII framing, decoder, carrier, collision, idle watch
	always_comb begin
		cd = cq;
		cd.link_m = link_pass;
		cd.link_s = cq.link_m;
		cd.speed_m = speed_100;
		cd.speed_s = cq.speed_m;
		cd.full_m = full_duplex;
		cd.full_s = cq.full_m;
		cd.act_m = lq.active;
		cd.act_s = cq.act_m;
		cd.symt_m = lq.word_tgl;
		cd.symt_s = cq.symt_m;
		cd.symt_d = cq.symt_s;
		cd.reqt_m = lq.req_tgl;
		cd.reqt_s = cq.reqt_m;
		cd.reqt_d = cq.reqt_s;
		cd.rx.stb = 1'b0;
		cd.tx_taken = 1'b0;
		sym_edge = cq.symt_s ^ cq.symt_d;
		req_edge = cq.reqt_s ^ cq.reqt_d;
		w = lq.word;
		dec = pcs_codec_pkg::dec_symbol(w.code);
		if (!cq.act_s) begin
			cd.act_arm = 1'b1;
		end

		if (!cq.link_s && cq.rxst != pcs_codec_pkg::RX_IDLE) begin
			cd.rx = '{1'b0, cq.rx.dv, pcs_codec_pkg::ERR_LINK, 1'b1};
			cd.rxst = pcs_codec_pkg::RX_IDLE;
		end else if (sym_edge && !w.locked) begin
			if (cq.rxst != pcs_codec_pkg::RX_IDLE) begin
				cd.rx = '{1'b0, cq.rx.dv, pcs_codec_pkg::ERR_UNLOCK, 1'b1};
			end
			cd.rxst = pcs_codec_pkg::RX_IDLE;
		end else if (sym_edge) begin
			cd.prev_idle = (w.code == pcs_codec_pkg::SYM_IDLE);
			case (cq.rxst)
				pcs_codec_pkg::RX_IDLE: begin
					if (!cq.speed_s) begin
						if (w.code == pcs_codec_pkg::SYM_J
								|| dec == {1'b1, pcs_codec_pkg::NIB_PREAMBLE}) begin
							cd.rx = '{1'b1, 1'b0, pcs_codec_pkg::NIB_PREAMBLE, 1'b1};
							cd.rxst = pcs_codec_pkg::RX_DATA;
							cd.prev_idle = 1'b0;
						end
					end else if (w.code == pcs_codec_pkg::SYM_J) begin
						cd.rxst = pcs_codec_pkg::RX_SSD;
					end else if (w.code != pcs_codec_pkg::SYM_IDLE) begin
						cd.rx = '{1'b0, 1'b1, pcs_codec_pkg::ERR_FALSE, 1'b1};
						cd.rxst = pcs_codec_pkg::RX_FALSE;
					end
				end
				pcs_codec_pkg::RX_SSD: begin
					if (w.code == pcs_codec_pkg::SYM_K) begin
						cd.rx = '{1'b1, 1'b0, pcs_codec_pkg::NIB_PREAMBLE, 1'b1};
						cd.rxst = pcs_codec_pkg::RX_DATA;
					end else begin
						cd.rx = '{1'b0, 1'b1, pcs_codec_pkg::ERR_FALSE, 1'b1};
						cd.rxst = pcs_codec_pkg::RX_FALSE;
					end
				end
				pcs_codec_pkg::RX_DATA: begin
					if (w.code == pcs_codec_pkg::SYM_T) begin
						cd.rxst = pcs_codec_pkg::RX_END;
					end else if (w.code == pcs_codec_pkg::SYM_IDLE && cq.prev_idle) begin
						cd.rx = '{1'b0, 1'b0, pcs_codec_pkg::NIB_ZERO, 1'b1};
						cd.rxst = pcs_codec_pkg::RX_IDLE;
					end else if (w.code == pcs_codec_pkg::SYM_H) begin
						cd.rx = '{1'b1, 1'b1, pcs_codec_pkg::ERR_TX, 1'b1};
					end else if (dec[4]) begin
						cd.rx = '{1'b1, 1'b0, dec[3:0], 1'b1};
					end else begin
						cd.rx = '{1'b1, 1'b1, pcs_codec_pkg::ERR_INVALID, 1'b1};
					end
				end
				pcs_codec_pkg::RX_END: begin
					if (w.code == pcs_codec_pkg::SYM_R) begin
						cd.rx = '{1'b0, 1'b0, pcs_codec_pkg::NIB_ZERO, 1'b1};
						cd.rxst = pcs_codec_pkg::RX_IDLE;
					end else begin
						cd.rx = '{1'b1, 1'b1, pcs_codec_pkg::ERR_EARLY_END, 1'b1};
						cd.rxst = pcs_codec_pkg::RX_FALSE;
					end
				end
				pcs_codec_pkg::RX_FALSE: begin
					if ((w.code == pcs_codec_pkg::SYM_IDLE && cq.prev_idle)
							|| w.code == pcs_codec_pkg::SYM_R) begin
						cd.rx = '{1'b0, 1'b0, pcs_codec_pkg::NIB_ZERO, 1'b1};
						cd.rxst = pcs_codec_pkg::RX_IDLE;
					end
				end
				default: begin
					cd.rxst = pcs_codec_pkg::RX_IDLE;
				end
			endcase
		end
		// Activity seen before the end must not re-raise carrier afterwards
		if (cd.rxst == pcs_codec_pkg::RX_IDLE && cq.rxst != pcs_codec_pkg::RX_IDLE) begin
			cd.act_arm = 1'b0;
		end

		carrier = (cq.rxst != pcs_codec_pkg::RX_IDLE)
			|| (cq.speed_s && cq.act_s && cq.act_arm && cq.link_s);
		tx_busy = mii_tx.en || cq.txst != pcs_codec_pkg::TX_IDLE;
		cd.crs = carrier || (!cq.full_s && mii_tx.en && cq.link_s);
		cd.col = !cq.full_s && carrier && tx_busy;

		// Idle watch over a fixed window while locked
		if (sym_edge) begin
			cd.last_locked = w.locked;
			if (w.locked && w.code == pcs_codec_pkg::SYM_IDLE && cq.idle_cnt != 2'h3) begin
				cd.idle_cnt = cq.idle_cnt + 2'h1;
			end
		end
		if (cq.win_cnt == WIN_W'(IDLE_WINDOW_CYCLES - 1)) begin
			cd.win_cnt = '0;
			cd.idle_cnt = 2'h0;
			if (cq.speed_s && cq.last_locked && cq.idle_cnt < pcs_codec_pkg::MIN_IDLES) begin
				cd.unlock_tgl = ~cq.unlock_tgl;
			end
		end else begin
			cd.win_cnt = cq.win_cnt + WIN_W'(1);
		end

		if (req_edge) begin
			if (!cq.link_s) begin
				// Link down: idles only, MAC nibbles are drained
				cd.tx_sym = pcs_codec_pkg::SYM_IDLE;
				cd.txst = pcs_codec_pkg::TX_IDLE;
				cd.tx_taken = mii_tx.en;
			end else begin
				case (cq.txst)
					pcs_codec_pkg::TX_IDLE: begin
						if (mii_tx.en) begin
							cd.tx_sym = pcs_codec_pkg::SYM_J;
							cd.txst = pcs_codec_pkg::TX_SSD2;
							cd.tx_taken = 1'b1;
						end else begin
							cd.tx_sym = pcs_codec_pkg::SYM_IDLE;
						end
					end
					pcs_codec_pkg::TX_SSD2: begin
						cd.tx_sym = pcs_codec_pkg::SYM_K;
						cd.txst = pcs_codec_pkg::TX_DATA;
						cd.tx_taken = mii_tx.en;
					end
					pcs_codec_pkg::TX_DATA: begin
						if (mii_tx.en) begin
							cd.tx_sym = mii_tx.er ? pcs_codec_pkg::SYM_H
								: pcs_codec_pkg::enc_nibble(mii_tx.d);
							cd.tx_taken = 1'b1;
						end else begin
							cd.tx_sym = pcs_codec_pkg::SYM_T;
							cd.txst = pcs_codec_pkg::TX_ESD2;
						end
					end
					pcs_codec_pkg::TX_ESD2: begin
						cd.tx_sym = pcs_codec_pkg::SYM_R;
						cd.txst = pcs_codec_pkg::TX_IDLE;
					end
					default: begin
						cd.tx_sym = pcs_codec_pkg::SYM_IDLE;
						cd.txst = pcs_codec_pkg::TX_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cq <= CORE_RST;
		end else begin
			cq <= cd;
		end
	end

	assign mii_rx = cq.rx;
	assign crs = cq.crs;
	assign col = cq.col;
	assign tx_taken = cq.tx_taken;
	assign line_tx_bit = lq.tx_bit;

	tx_idle_fill_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(req_edge && cq.txst == pcs_codec_pkg::TX_IDLE && !mii_tx.en)
		|=> (cq.tx_sym == pcs_codec_pkg::SYM_IDLE && cq.txst == pcs_codec_pkg::TX_IDLE))
		else $error("idle not sent between frames");
	tx_ssd_pair_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(req_edge && cq.txst == pcs_codec_pkg::TX_IDLE && mii_tx.en && cq.link_s)
		|=> cq.tx_sym == pcs_codec_pkg::SYM_J ##[4:40] cq.tx_sym == pcs_codec_pkg::SYM_K)
		else $error("start delimiter pair not sent");
	tx_err_sym_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(req_edge && cq.txst == pcs_codec_pkg::TX_DATA && mii_tx.en && mii_tx.er && cq.link_s)
		|=> cq.tx_sym == pcs_codec_pkg::SYM_H)
		else $error("error symbol not sent");
	false_carrier_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(cq.rx.stb && cq.rx.er && !cq.rx.dv && $past(cq.rxst) != pcs_codec_pkg::RX_DATA
			&& $past(cq.rxst) != pcs_codec_pkg::RX_FALSE && cq.link_s && $past(w.locked))
		|-> cq.rx.d == pcs_codec_pkg::ERR_FALSE)
		else $error("false carrier nibble wrong");
	full_dup_crs_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(cq.full_s && cq.rxst == pcs_codec_pkg::RX_IDLE && !cq.act_s) |=> !cq.crs)
		else $error("carrier raised by own transmit in full duplex");
	half_dup_crs_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(!cq.full_s && mii_tx.en && cq.link_s) |=> cq.crs)
		else $error("carrier missing during half duplex transmit");
	collision_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(!cq.full_s && cq.rxst != pcs_codec_pkg::RX_IDLE && mii_tx.en) |=> cq.col)
		else $error("collision not flagged");
	decoder_off_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(sym_edge && !w.locked && cq.rxst == pcs_codec_pkg::RX_IDLE) |=> !cq.rx.stb)
		else $error("decoder active while unlocked");
	idle_watch_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(cq.win_cnt == WIN_W'(IDLE_WINDOW_CYCLES - 1) && cq.speed_s && cq.last_locked
			&& cq.idle_cnt < pcs_codec_pkg::MIN_IDLES) |=> $changed(cq.unlock_tgl))
		else $error("lock not dropped after idle window");
	link_fail_unl_a: assert property (@(posedge line_clk) disable iff (!arst_n)
		!lq.link_s |=> !lq.locked)
		else $error("descrambler locked during link failure");
	cipher_bypass_a: assert property (@(posedge line_clk) disable iff (!arst_n)
		!lq.speed_s |=> lq.tx_bit == $past(lq.tx_sh[4]))
		else $error("scrambler not bypassed in 10M mode");

endmodule

// >>> dv/line_peer.sv
module line_peer (
	// Line clock and mode
	input wire logic line_clk,
	input wire logic speed_100,
	// Bit streams
	input wire logic tx_bit,
	output logic rx_bit
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] tx_q[$];
	logic [4:0] cap_q[$];
	logic [10:0] scr = 11'h5a5;
	logic [10:0] hist = '0;
	logic [4:0] out_sr = 5'h1f;
	logic [4:0] in_sr = 5'h1f;
	int out_n = 0;
	int in_n = 0;
	int ones = 0;
	bit locked = 0;
	bit in_frame = 0;
	bit last = 0;
	logic kp;
	logic pb;
	initial rx_bit = 1'b0;
	// Far-end sender: idles unless groups are queued, first bit first
	always @(negedge line_clk) begin
		if (out_n == 0) out_sr = (tx_q.size() > 0) ? tx_q.pop_front() : 5'h1f;
		scr = {scr[9:0], scr[10] ^ scr[8]};
		rx_bit <= out_sr[4] ^ (speed_100 & scr[0]);
		out_sr = {out_sr[3:0], 1'b1};
		out_n = (out_n + 1) % 5;
	end
	// Far-end receiver: learns the key from idles, then frames on J
	// Sampled on the falling edge, after the launched bit has settled
	always @(negedge line_clk) begin
		kp = speed_100 & (hist[10] ^ hist[8]);
		pb = tx_bit ^ kp;
		hist = {hist[9:0], locked ? (hist[10] ^ hist[8]) : ~tx_bit};
		ones = pb ? ones + 1 : 0;
		if (ones > 40) locked = 1;
		in_sr = {in_sr[3:0], pb};
		in_n = (in_n + 1) % 5;
		if (locked && !in_frame && in_sr == 5'h18) begin
			in_frame = 1;
			in_n = 0;
		end
		// The group after R is kept too, so the idle that follows is seen
		if (in_frame && in_n == 0) begin
			cap_q.push_back(in_sr);
			in_frame = !last;
			last = (in_sr == 5'h07);
		end
	end
endmodule

// >>> dv/tb_fast_ethernet_pcs_codec.sv
module tb_fast_ethernet_pcs_codec;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic line_clk = 1'b0;
	logic arst_n = 1'b0;
	logic speed_100 = 1'b1;
	logic full_duplex = 1'b1;
	logic link_pass = 1'b1;
	pcs_codec_pkg::mii_tx_s mii_tx = '0;
	pcs_codec_pkg::mii_rx_s mii_rx;
	logic tx_taken;
	logic crs;
	logic col;
	logic line_rx_bit;
	logic line_tx_bit;
	int bad_count = 0;
	int compares = 0;
	bit crs_seen = 0;
	bit col_seen = 0;
	bit last_act = 0;
	logic [5:0] rx_q[$];
	logic [4:0] sym_tab [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
	// Receive error rows: start delimiter first, bad group, error nibble
	logic [9:0] err_tab [5] = '{
		{1'b1, 5'h04, 4'h8},
		{1'b1, 5'h00, 4'h7},
		{1'b1, 5'h18, 4'h7},
		{1'b1, 5'h0d, 4'h6},
		{1'b0, 5'h0e, 4'he}
	};
	fast_ethernet_pcs_codec #(.IDLE_WINDOW_CYCLES(600)) fast_ethernet_pcs_codec_inst (
		.core_clk(core_clk), .line_clk(line_clk), .arst_n(arst_n),
		.speed_100(speed_100), .full_duplex(full_duplex), .link_pass(link_pass),
		.mii_tx(mii_tx), .tx_taken(tx_taken), .mii_rx(mii_rx), .crs(crs), .col(col),
		.line_rx_bit(line_rx_bit), .line_tx_bit(line_tx_bit)
	);
	line_peer line_peer_inst (
		.line_clk(line_clk), .speed_100(speed_100),
		.tx_bit(line_tx_bit), .rx_bit(line_rx_bit)
	);
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	// Odd offset keeps line edges apart from core edges
	initial begin
		#2.5;
		forever #16 line_clk = ~line_clk;
	end
	// Receive log: active nibbles plus the one that ends activity
	// Sampled mid-cycle so registered outputs have settled
	always @(negedge core_clk) begin
		crs_seen = crs_seen | (crs === 1'b1);
		col_seen = col_seen | (col === 1'b1);
		if (mii_rx.stb === 1'b1) begin
			if (mii_rx.dv || mii_rx.er || last_act) rx_q.push_back(mii_rx[6:1]);
			last_act = mii_rx.dv | mii_rx.er;
		end
	end
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic results();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic give_up(input string what);
		bad_count++;
		$display("MISMATCH %s expected done seen timeout", what);
		results();
	endtask
	task automatic ended(input string name);
		$display("test %s done", name);
	endtask
	function automatic logic seen(input logic [4:0] v);
		foreach (rx_q[i]) begin
			if (rx_q[i][4:0] === v) return 1'b1;
		end
		return 1'b0;
	endfunction
	task automatic start();
		@(negedge core_clk);
		rx_q.delete();
		line_peer_inst.cap_q.delete();
		line_peer_inst.in_frame = 0;
		line_peer_inst.last = 0;
		crs_seen = 0;
		col_seen = 0;
	endtask
	task automatic send(input logic [4:0] s[$]);
		foreach (s[i]) line_peer_inst.tx_q.push_back(s[i]);
	endtask
	task automatic settle(input int syms);
		int n;
		n = 0;
		while (line_peer_inst.tx_q.size() > 0 && n < 20000) begin
			@(posedge line_clk);
			n++;
		end
		if (n >= 20000) give_up("line drain");
		repeat (syms * 5) @(posedge line_clk);
	endtask
	// Each nibble is held until the design reports it taken
	task automatic tx_frame(input logic [3:0] nib[$], input int err_at);
		int n;
		foreach (nib[i]) begin
			@(negedge core_clk);
			mii_tx = '{en: 1'b1, er: (i == err_at), d: nib[i]};
			n = 0;
			do begin
				@(negedge core_clk);
				n++;
			end while (tx_taken !== 1'b1 && n < 200);
			if (n >= 200) give_up("tx_taken");
		end
		mii_tx = '0;
	endtask
	initial begin
		logic [3:0] nib[$];
		logic [4:0] sq[$];
		repeat (4) @(negedge core_clk);
		check("reset outputs", 16'h0, {5'h0, mii_rx, crs, col, tx_taken, line_tx_bit});
		@(negedge core_clk);
		arst_n = 1'b1;
		repeat (2000) @(negedge core_clk);
		check("far lock", 16'h1, 16'(line_peer_inst.locked));
		ended("reset");
		start();
		nib = '{4'h5, 4'h5};
		sq = '{5'h18, 5'h11};
		foreach (sym_tab[i]) begin
			nib.push_back(4'(i));
			sq.push_back(sym_tab[i]);
		end
		sq.push_back(5'h0d);
		sq.push_back(5'h07);
		send(sq);
		tx_frame(nib, -1);
		settle(8);
		foreach (sym_tab[i]) begin
			check("tx sym", 16'(sym_tab[i]), 16'(line_peer_inst.cap_q[i + 2]));
			check("rx nib", 16'({2'b10, 4'(i)}), 16'(rx_q[i + 1]));
		end
		sq = line_peer_inst.cap_q;
		check("tx start", {6'h0, 5'h18, 5'h11}, {6'h0, sq[0], sq[1]});
		check("tx end", {1'b0, 5'h0d, 5'h07, 5'h1f}, {1'b0, sq[18], sq[19], sq[20]});
		check("rx first", 16'h25, 16'(rx_q[0]));
		check("rx end", 16'h0, 16'(rx_q[17]));
		check("rx count", 16'd18, 16'(rx_q.size()));
		check("crs rx", 16'h1, 16'(crs_seen));
		check("crs idle", 16'h0, 16'(crs));
		ended("data table");
		start();
		tx_frame('{4'h5, 4'h5, 4'ha, 4'hb}, 3);
		settle(8);
		sq = line_peer_inst.cap_q;
		check("tx error", {6'h0, 5'h16, 5'h04}, {6'h0, sq[2], sq[3]});
		check("crs full", 16'h0, 16'(crs_seen));
		ended("transmit error");
		@(negedge core_clk);
		full_duplex = 1'b0;
		start();
		tx_frame('{4'h5, 4'h5, 4'h1}, -1);
		settle(8);
		check("crs half", 16'h1, 16'(crs_seen));
		check("col tx only", 16'h0, 16'(col_seen));
		start();
		send('{5'h18, 5'h11, 5'h0b, 5'h0b, 5'h0b, 5'h0b, 5'h0d, 5'h07});
		tx_frame('{4'h5, 4'h5, 4'h1, 4'h2, 4'h3}, -1);
		settle(8);
		check("col both", 16'h1, 16'(col_seen));
		@(negedge core_clk);
		full_duplex = 1'b1;
		ended("carrier and collision");
		foreach (err_tab[i]) begin
			start();
			sq.delete();
			if (err_tab[i][9]) sq = '{5'h18, 5'h11, 5'h0b};
			sq.push_back(err_tab[i][8:4]);
			send(sq);
			settle(8);
			check("rx error", 16'h1, 16'(seen({1'b1, err_tab[i][3:0]})));
			check("rx dv", 16'(err_tab[i][9]), 16'(rx_q[0][5]));
			check("crs end", 16'h0, 16'(crs));
		end
		ended("receive errors");
		start();
		sq = '{5'h18, 5'h11};
		repeat (120) sq.push_back(5'h0b);
		send(sq);
		settle(40);
		check("lost lock", 16'h1, 16'(seen(5'h12)));
		check("unlocked", 16'h1, 16'(rx_q.size() < 110));
		ended("lock loss");
		start();
		sq = '{5'h18, 5'h11};
		repeat (30) sq.push_back(5'h0b);
		send(sq);
		repeat (50) @(posedge line_clk);
		@(negedge core_clk);
		link_pass = 1'b0;
		settle(8);
		check("link fail", 16'h1, 16'(seen(5'h13)));
		start();
		send('{5'h18, 5'h11, 5'h0b, 5'h0d, 5'h07});
		settle(8);
		check("crs link down", 16'h0, 16'(crs_seen));
		@(negedge core_clk);
		link_pass = 1'b1;
		settle(40);
		ended("link failure");
		@(negedge core_clk);
		speed_100 = 1'b0;
		settle(40);
		start();
		send('{5'h18, 5'h0b, 5'h1e, 5'h0d, 5'h07});
		tx_frame('{4'h5, 4'h5, 4'h3}, -1);
		settle(8);
		sq = line_peer_inst.cap_q;
		check("tx plain", {1'b0, 5'h18, 5'h11, 5'h15}, {1'b0, sq[0], sq[1], sq[2]});
		check("rx plain", {4'h0, 6'h25, 6'h20}, {4'h0, rx_q[0], rx_q[2]});
		check("crs plain", 16'h1, 16'(crs_seen));
		ended("plain mode");
		results();
	end
endmodule
